// ===== hdl/ocf_pkg.sv
// Purpose: Constants shared by the over-current fault response block.
// Assumes: 100 MHz clock; delay time unit counted in 1 us base ticks.
// Notes:   Policy byte layout is response[7:6], retries[5:3], delay[2:0].
package ocf_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int BASE_TICK_NS = 1000;
  localparam int BASE_TICK_CYC = (BASE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Policy byte fields
  // ----------------------------------------------------------------
  localparam int RESP_MSB = 7;
  localparam int RESP_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;
  localparam logic [7:0] POLICY_RST = 8'h80;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  typedef enum logic [1:0] {
    OCF_RESP_LIMIT_FOREVER = 2'h0,
    OCF_RESP_LIMIT_ABOVE_LV = 2'h1,
    OCF_RESP_LIMIT_DELAY = 2'h2,
    OCF_RESP_SHUTDOWN = 2'h3
  } ocf_resp_t;

  // ----------------------------------------------------------------
  // Sequencer states, Gray coded along the usual path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OCF_ST_OFF = 3'h0,
    OCF_ST_RUN = 3'h1,
    OCF_ST_LIMIT = 3'h3,
    OCF_ST_WAIT = 3'h2,
    OCF_ST_RESTART = 3'h6,
    OCF_ST_LATCH = 3'h7
  } ocf_state_t;

endpackage

// ===== hdl/ocf_fault_response.sv
// Purpose: Output over-current fault response sequencer with retry policy.
// Assumes: Policy byte written by the host command decoder on this clock;
//          delay time unit comes from a separate timing register input.
// Notes:   Pins are synchronised here; clear and write strobes are not.
//
// How it works
// RQ1 - Code 10: hold current limit for delay, then retry policy if still limiting.
// RQ2 - Code 11: disable output at once on over-current, then retry policy.
// RQ3 - Retry code zero: never restart, stay off until fault cleared.
// RQ4 - Codes one to six: that many restarts, then off until cleared.
// RQ5 - Restart starts are spaced by multiplier times delay unit.
// RQ6 - Code 111 retries forever until commanded off, bias lost, other fault.
// RQ7 - Delay field selects one to 128 units, doubling per code.
// RQ8 - Delay sets ride-through time and retry spacing alike.
// RQ9 - Delay unit length comes from the separate timing register.
// RQ10 - Every response sets the fault status bit and alerts the host.
// RQ11 - Code 00: current limit indefinitely, regardless of voltage.
// RQ12 - Code 01: limit while voltage above threshold, else shut down and retry.
// RQ13 - Fault cleared by clear strobe, off-then-on command, bias loss or reset.
// RQ14 - Attempt counter cleared with fault; recurring over-current fails attempt.
`timescale 1ns/10ps
`default_nettype none

module ocf_fault_response
  import ocf_pkg::*;
#(
  parameter int TICK_CYC = BASE_TICK_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_oc_detect,
  input wire logic i_vout_low,
  input wire logic i_bias_ok,
  input wire logic i_other_fault,
  input wire logic i_cmd_on,
  input wire logic i_clear_fault,
  input wire logic i_policy_wr,
  input wire logic [7:0] i_policy_wdata,
  input wire logic [7:0] i_delay_unit,
  output logic [7:0] o_policy,
  output logic o_output_en,
  output logic o_current_limit,
  output logic o_oc_fault_status,
  output logic o_alert,
  output logic [2:0] o_attempts,
  output logic [2:0] o_state
);

  // The base divider is sixteen bits wide
  if (TICK_CYC < 1 || TICK_CYC > 65535) begin : g_bad_tick
    $error("TICK_CYC out of range");
  end

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  localparam int NPIN = 5;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta_reg;
  logic [NPIN-1:0] pin_reg;
  assign pin_raw = {i_oc_detect, i_vout_low, i_bias_ok, i_other_fault, i_cmd_on};
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= '0;
      pin_reg <= '0;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_reg <= pin_meta_reg;
    end
  end

  logic oc;
  logic vlow;
  logic bias;
  logic other;
  logic cmd_on;
  assign {oc, vlow, bias, other, cmd_on} = pin_reg;

  // ----------------------------------------------------------------
  // Base tick divider
  // ----------------------------------------------------------------
  logic [15:0] div_reg;
  logic [15:0] div_next;
  logic tick;
  assign tick = (div_reg == 16'h0000);
  always_comb begin
    div_next = tick ? 16'(TICK_CYC - 1) : div_reg - 16'h0001;
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_next;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  ocf_state_t state_reg;
  ocf_state_t state_next;
  logic [7:0] policy_reg;
  logic [7:0] policy_next;
  logic [7:0] unit_cnt_reg;
  logic [7:0] unit_cnt_next;
  logic [7:0] units_left_reg;
  logic [7:0] units_left_next;
  logic [2:0] attempts_reg;
  logic [2:0] attempts_next;
  logic status_reg;
  logic status_next;
  logic alert_reg;
  logic alert_next;
  logic cmd_on_d_reg;
  logic out_en_reg;
  logic out_en_next;
  logic limit_reg;
  logic limit_next;

  ocf_resp_t resp;
  logic [2:0] retries;
  logic [2:0] delay_code;
  logic [7:0] unit_len;
  logic expire;
  logic load_timer;
  logic cmd_rise;
  logic clear_any;
  logic retry_ok;
  logic oc_event;
  logic shut;

  assign resp = ocf_resp_t'(policy_reg[RESP_MSB:RESP_LSB]);
  assign retries = policy_reg[RETRY_MSB:RETRY_LSB];
  assign delay_code = policy_reg[DELAY_MSB:DELAY_LSB];
  // Unit length from the timing register; zero treated as one tick
  assign unit_len = (i_delay_unit == 8'h00) ? 8'h01 : i_delay_unit; // RQ9
  assign expire = tick && (unit_cnt_reg == 8'h00) && (units_left_reg == 8'h00);
  assign cmd_rise = cmd_on && !cmd_on_d_reg;
  assign clear_any = i_clear_fault || cmd_rise; // RQ13
  assign retry_ok = (retries == RETRY_FOREVER) || (attempts_reg < retries); // RQ4 RQ6

  always_comb begin
    state_next = state_reg;
    policy_next = i_policy_wr ? i_policy_wdata : policy_reg;
    attempts_next = attempts_reg;
    load_timer = 1'b0;
    oc_event = 1'b0;
    shut = 1'b0;
    unique case (state_reg)
      OCF_ST_OFF: begin
        if (cmd_on && !other) begin
          state_next = OCF_ST_RUN;
        end
      end
      OCF_ST_RUN: begin
        if (oc) begin
          oc_event = 1'b1; // RQ10
          if (resp == OCF_RESP_SHUTDOWN) begin
            shut = 1'b1; // RQ2
          end else begin
            state_next = OCF_ST_LIMIT; // RQ11
            load_timer = 1'b1; // RQ1
          end
        end
      end
      OCF_ST_LIMIT: begin
        unique case (resp)
          OCF_RESP_LIMIT_FOREVER: state_next = OCF_ST_LIMIT; // RQ11
          OCF_RESP_LIMIT_ABOVE_LV: shut = vlow; // RQ12
          OCF_RESP_LIMIT_DELAY: begin
            if (!oc) begin
              state_next = OCF_ST_RUN;
            end else if (expire) begin
              shut = 1'b1; // RQ1 RQ8
            end
          end
          OCF_RESP_SHUTDOWN: shut = 1'b1;
        endcase
        // Limit ends when the load falls back under the threshold
        if (!oc && resp != OCF_RESP_LIMIT_DELAY) begin
          state_next = OCF_ST_RUN;
        end
      end
      OCF_ST_WAIT: begin
        if (expire) begin
          state_next = OCF_ST_RESTART;
          attempts_next = (retries == RETRY_FOREVER) ? attempts_reg : attempts_reg + 3'h1;
          load_timer = 1'b1; // RQ5
        end
      end
      OCF_ST_RESTART: begin
        if (oc) begin
          oc_event = 1'b1; // RQ14
          // Timer keeps running so start-to-start spacing is one delay
          state_next = retry_ok ? OCF_ST_WAIT : OCF_ST_LATCH; // RQ4 RQ5
        end else if (expire) begin
          state_next = OCF_ST_RUN;
          attempts_next = 3'h0;
        end
      end
      OCF_ST_LATCH: begin
        if (clear_any) begin
          state_next = OCF_ST_OFF; // RQ3
        end
      end
      default: state_next = OCF_ST_OFF;
    endcase
    if (shut) begin
      load_timer = 1'b1;
      state_next = (retries == RETRY_NONE || !retry_ok) ? OCF_ST_LATCH : OCF_ST_WAIT; // RQ3
    end
    if (clear_any) begin
      attempts_next = 3'h0; // RQ14
    end
    // Command off, bias loss or a foreign fault stop everything
    if (!cmd_on || !bias || other) begin
      state_next = OCF_ST_OFF; // RQ6
      attempts_next = 3'h0;
    end
  end

  always_comb begin
    if (load_timer) begin
      unit_cnt_next = unit_len - 8'h01;
      units_left_next = 8'((9'h001 << delay_code) - 9'h001); // RQ7
    end else if (tick) begin
      unit_cnt_next = (unit_cnt_reg == 8'h00) ? unit_len - 8'h01 : unit_cnt_reg - 8'h01;
      units_left_next = units_left_reg;
      if (unit_cnt_reg == 8'h00 && units_left_reg != 8'h00) begin
        units_left_next = units_left_reg - 8'h01;
      end
    end else begin
      unit_cnt_next = unit_cnt_reg;
      units_left_next = units_left_reg;
    end
  end

  always_comb begin
    // A new over-current wins over a clear in the same cycle
    status_next = oc_event || (status_reg && !clear_any && bias); // RQ10 RQ13
    alert_next = oc_event || (alert_reg && !clear_any && bias);
    out_en_next = (state_next == OCF_ST_RUN) || (state_next == OCF_ST_LIMIT) ||
                  (state_next == OCF_ST_RESTART); // RQ2
    limit_next = (state_next == OCF_ST_LIMIT);
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= OCF_ST_OFF;
      policy_reg <= POLICY_RST;
      unit_cnt_reg <= 8'h00;
      units_left_reg <= 8'h00;
      attempts_reg <= 3'h0;
      status_reg <= 1'b0;
      alert_reg <= 1'b0;
      cmd_on_d_reg <= 1'b0;
      out_en_reg <= 1'b0;
      limit_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      policy_reg <= policy_next;
      unit_cnt_reg <= unit_cnt_next;
      units_left_reg <= units_left_next;
      attempts_reg <= attempts_next;
      status_reg <= status_next;
      alert_reg <= alert_next;
      cmd_on_d_reg <= cmd_on;
      out_en_reg <= out_en_next;
      limit_reg <= limit_next;
    end
  end

  assign o_policy = policy_reg;
  assign o_output_en = out_en_reg;
  assign o_current_limit = limit_reg;
  assign o_oc_fault_status = status_reg;
  assign o_alert = alert_reg;
  assign o_attempts = attempts_reg;
  assign o_state = state_reg;

endmodule

`default_nettype wire

// ===== testbench/ocf_fault_response_sva.sv
// Purpose: Port checks for the fault response sequencer.
// Assumes: Bound to every ocf_fault_response instance.
// Notes: Wait length allows one tick of divider phase.
`timescale 1ns/10ps
`default_nettype none
module ocf_sva
  import ocf_pkg::*;
#(
  parameter int TICK_CYC = BASE_TICK_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_bias_ok,
  input wire logic i_clear_fault,
  input wire logic i_policy_wr,
  input wire logic [7:0] i_policy_wdata,
  input wire logic [7:0] i_delay_unit,
  input wire logic [7:0] o_policy,
  input wire logic o_output_en,
  input wire logic o_current_limit,
  input wire logic o_oc_fault_status,
  input wire logic o_alert,
  input wire logic [2:0] o_attempts,
  input wire logic [2:0] o_state
);
  logic [31:0] wcnt_reg;
  logic [31:0] wcnt_next;
  logic [31:0] lim;
  always_comb begin
    wcnt_next = (o_state == OCF_ST_WAIT) ? wcnt_reg + 32'h1 : 32'h0;
    lim = (32'h1 << o_policy[2:0]) * 32'(TICK_CYC)
      * ((i_delay_unit == 8'h0) ? 32'h1 : {24'h0, i_delay_unit});
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wcnt_reg <= 32'h0;
    end else begin
      wcnt_reg <= wcnt_next;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_shut; o_state == OCF_ST_RUN ##1 o_state == OCF_ST_WAIT; endsequence
  sequence s_retry; o_state == OCF_ST_WAIT ##1 o_state == OCF_ST_RESTART; endsequence
  property p_wr; i_policy_wr |=> o_policy == $past(i_policy_wdata); endproperty
  property p_flag; s_shut |-> o_oc_fault_status && o_alert; endproperty
  property p_off;
    o_state inside {OCF_ST_WAIT, OCF_ST_LATCH} && $stable(o_state) |-> !o_output_en;
  endproperty
  property p_none; o_state == OCF_ST_RESTART |-> o_policy[5:3] != RETRY_NONE; endproperty
  property p_cnt;
    o_state == OCF_ST_RESTART && o_policy[5:3] != RETRY_FOREVER |-> o_attempts <= o_policy[5:3];
  endproperty
  property p_space;
    s_retry |-> wcnt_reg + 32'(TICK_CYC) >= lim && wcnt_reg <= lim + 32'h2;
  endproperty
  property p_bias; $fell(i_bias_ok) |-> ##[1:6] o_state == OCF_ST_OFF; endproperty
  property p_clr;
    i_clear_fault && o_state == OCF_ST_LATCH |=> o_state == OCF_ST_OFF
      && !o_oc_fault_status && !o_alert && o_attempts == 3'h0;
  endproperty
  property p_lim; o_state == OCF_ST_LIMIT && $stable(o_state) |-> o_current_limit; endproperty
  a_wr: assert property (p_wr) else $error("policy readback");
  a_flag: assert property (p_flag) else $error("status not set");
  a_off: assert property (p_off) else $error("output on while off");
  a_none: assert property (p_none) else $error("restart with no retries");
  a_cnt: assert property (p_cnt) else $error("too many restarts");
  a_space: assert property (p_space) else $error("restart spacing");
  a_bias: assert property (p_bias) else $error("bias loss ignored");
  a_clr: assert property (p_clr) else $error("clear ignored");
  a_lim: assert property (p_lim) else $error("limit flag low");
endmodule
bind ocf_fault_response ocf_sva #(.TICK_CYC(TICK_CYC)) u_sva (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_bias_ok(i_bias_ok), .i_clear_fault(i_clear_fault), .i_policy_wr(i_policy_wr),
  .i_policy_wdata(i_policy_wdata), .i_delay_unit(i_delay_unit), .o_policy(o_policy),
  .o_output_en(o_output_en), .o_current_limit(o_current_limit),
  .o_oc_fault_status(o_oc_fault_status), .o_alert(o_alert), .o_attempts(o_attempts),
  .o_state(o_state));
`default_nettype wire

// ===== testbench/ocf_host_model.sv
// Purpose: Host side that writes the policy byte and clears faults.
// Assumes: Strobes are one-cycle pulses on the block clock.
// Notes: Released data shows its inverse so stale values never pass.
`timescale 1ns/10ps
`default_nettype none
module ocf_host_model (
  input wire logic i_clk,
  output logic o_policy_wr,
  output logic [7:0] o_policy_wdata,
  output logic o_clear_fault
);
  initial begin
    o_policy_wr = 1'b0;
    o_policy_wdata = 8'h00;
    o_clear_fault = 1'b0;
  end
  task automatic write_policy(input logic [7:0] b);
    @(posedge i_clk);
    #1;
    o_policy_wr = 1'b1;
    o_policy_wdata = b;
    @(posedge i_clk);
    #1;
    o_policy_wr = 1'b0;
    o_policy_wdata = ~b;
  endtask
  task automatic clear_fault();
    @(posedge i_clk);
    #1;
    o_clear_fault = 1'b1;
    @(posedge i_clk);
    #1;
    o_clear_fault = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== testbench/test_overcurrent_fault_response.sv
// Purpose: Self-checking bench for the fault response sequencer.
// Assumes: Short tick parameter keeps every delay brief.
// Notes: State changes are compared against a queue of predictions.
`timescale 1ns/10ps
`default_nettype none
module test_overcurrent_fault_response;
  import ocf_pkg::*;
  logic clk, nrst, oc, vlow, other, bias, cmd, wr, clr, en, lim, flag, alert;
  logic [7:0] wd, unit, pol;
  logic [2:0] att, st, prev_st;
  logic [7:0] exp_q[$];
  int num_errors, tests_run, cycles;
  ocf_host_model u_ocf_host_model (.i_clk(clk), .o_policy_wr(wr), .o_policy_wdata(wd),
    .o_clear_fault(clr));
  ocf_fault_response #(.TICK_CYC(2)) u_ocf_fault_response (.i_clk(clk), .i_nrst(nrst),
    .i_oc_detect(oc), .i_vout_low(vlow), .i_bias_ok(bias), .i_other_fault(other),
    .i_cmd_on(cmd), .i_clear_fault(clr), .i_policy_wr(wr), .i_policy_wdata(wd),
    .i_delay_unit(unit), .o_policy(pol), .o_output_en(en), .o_current_limit(lim),
    .o_oc_fault_status(flag), .o_alert(alert), .o_attempts(att), .o_state(st));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    // Look just after the edge so the state has settled
    while (st !== s && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (st !== s) check({5'h0, st}, {5'h0, s});
  endtask
  always @(negedge clk) begin
    if (nrst && st !== prev_st) begin
      prev_st = st;
      check({5'h0, st}, exp_q.size() > 0 ? exp_q.pop_front() : 8'hFF);
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    {nrst, oc, vlow, other, prev_st} = '0;
    {bias, cmd, unit} = {2'b11, 8'h01};
    void'($urandom(32'hB7AD8707));
    exp_q.push_back(8'(OCF_ST_RUN));
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    wait_st(OCF_ST_RUN);
    check(pol, 8'h80);
    for (int i = 0; i < 3; i++) begin
      u_ocf_host_model.write_policy(i == 0 ? 8'h00 : (i == 1 ? 8'h87 : 8'h40));
      exp_q.push_back(8'(OCF_ST_LIMIT));
      exp_q.push_back(8'(OCF_ST_RUN));
      oc = 1'b1;
      repeat (40) @(posedge clk);
      #1;
      check({5'h0, en, lim, flag & alert}, 8'h07);
      oc = 1'b0;
      wait_st(OCF_ST_RUN);
    end
    for (int n = 1; n <= 7; n++) begin
      unit = 8'($urandom % 3);
      // Ride-through and low-voltage shutdown lead into the retry policy too
      u_ocf_host_model.write_policy({(n == 1 ? 2'b10 : (n == 2 ? 2'b01 : 2'b11)), 3'(n),
        3'($urandom % 2)});
      check(pol[5:0], {3'(n), wd[2:0] ^ 3'h7});
      if (n < 3) exp_q.push_back(8'(OCF_ST_LIMIT));
      exp_q.push_back(8'(OCF_ST_WAIT));
      for (int i = 1; i <= (n == 7 ? 2 : n); i++) begin
        exp_q.push_back(8'(OCF_ST_RESTART));
        exp_q.push_back(i == n ? 8'(OCF_ST_LATCH) : 8'(OCF_ST_WAIT));
      end
      exp_q.push_back(8'(OCF_ST_OFF));
      exp_q.push_back(8'(OCF_ST_RUN));
      oc = 1'b1;
      vlow = (n == 2);
      wait_st(n == 7 ? OCF_ST_RESTART : OCF_ST_LATCH);
      if (n == 7) begin
        wait_st(OCF_ST_WAIT);
        wait_st(OCF_ST_RESTART);
        wait_st(OCF_ST_WAIT);
        bias = 1'b0;
        oc = 1'b0;
        wait_st(OCF_ST_OFF);
        check({7'h0, flag}, 8'h00);
        bias = 1'b1;
      end else begin
        check({5'h0, att}, 8'(n));
        check({7'h0, en}, 8'h00);
        oc = 1'b0;
        vlow = 1'b0;
        repeat (4) @(posedge clk);
        u_ocf_host_model.clear_fault();
      end
      wait_st(OCF_ST_RUN);
    end
    // A foreign fault forces the output off until it goes away
    exp_q.push_back(8'(OCF_ST_OFF));
    exp_q.push_back(8'(OCF_ST_RUN));
    other = 1'b1;
    wait_st(OCF_ST_OFF);
    check({7'h0, en}, 8'h00);
    other = 1'b0;
    wait_st(OCF_ST_RUN);
    // The monitor takes the last note at the falling edge
    @(negedge clk);
    #1;
    check(8'(exp_q.size()), 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
